// ===== common/amp_seq_defines.vh
// Register offsets, field positions, reset values and timing counts of the power sequencer
// Function
// - Reset held enters sleep, clears all state
// - After release, registers default, still sleeping
// - Clearing global sleep bit starts normal operation
// - Pulse outputs low while reset held
// - Divided clock is crystal or crystal/2
// - Mute pin latched at reset release
// - Each channel ramps independently
// - Ramp-up channel not powered stays grounded
// - Channel enable ramps duty zero to half
// - Muted channel outputs half duty, no audio
// - Half-bridge channel sleep ramps level to ground; global sleep drops it at once
// - Rate converter locks; optional lock interrupt
// - Optional interrupt on ramp completion
// - Full-bridge channels switch directly, no ramp
`ifndef AMP_SEQ_DEFINES_VH
`define AMP_SEQ_DEFINES_VH

`define ADDR_POWER_CTRL   8'h02
`define ADDR_CHAN_SLEEP   8'h03
`define ADDR_RAMP_CFG     8'h05
`define ADDR_CHAN_SILENCE 8'h13
`define ADDR_IRQ_CFG      8'h2a
`define ADDR_FB_COEF_HI   8'h35
`define ADDR_FB_COEF_MID  8'h36
`define ADDR_FB_COEF_LO   8'h37
`define ADDR_FB_CTRL      8'h38
`define ADDR_STATUS       8'h39
`define ADDR_DEC_HI       8'h3a
`define ADDR_DEC_MID      8'h3b
`define ADDR_DEC_LO       8'h3c

`define RST_POWER_CTRL    8'h81
`define RST_CHAN_SLEEP    8'hff
`define RST_RAMP_CFG      8'h01
`define RST_CHAN_SILENCE  8'h00
`define RST_IRQ_CFG       8'h00
`define RST_FB_COEF       8'h00
`define RST_FB_CTRL       8'h00

`define POWER_SLEEP_BIT   0
`define RAMP_SPD_LSB      0
`define RAMP_MODE_LSB     3
`define IRQ_LOCK_BIT      0
`define IRQ_RAMP_BIT      1
`define FB_CLEAR_BIT      0
`define FB_RUN_BIT        1

`define RAMP_MODE_UP      2'b11
`define RAMP_MODE_DOWN    2'b01

// Lock settle time in ns after the audio clocks run
`define LOCK_TIME_NS      1000
`define CLK_PERIOD_NS     10
`define LOCK_CYCLES       ((`LOCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== hdl/chan_ramp.v
// One pulse-width channel with soft ramp between ground and half duty
`timescale 1ns/1ps
`include "amp_seq_defines.vh"
module chan_ramp #(
	parameter DW = 8
) (
	input  wire          divided_clock_output_i,
	input  wire          reset_i,
	input  wire          run_i,
	input  wire          sleep_i,
	input  wire          silence_i,
	input  wire [1:0]    mode_i,
	input  wire [1:0]    speed_i,
	input  wire [DW-1:0] audio_i,
	input  wire [DW-1:0] phase_i,
	output reg           pwm_o,
	output reg           done_o
);
	localparam [DW-1:0] HALF = {1'b1, {(DW-1){1'b0}}};
	localparam [DW-1:0] ZERO = {DW{1'b0}};

	reg [DW-1:0] level_q;
	reg [7:0]    pace_q;
	reg          busy_q;
	wire         ramp_up   = (mode_i == `RAMP_MODE_UP);
	wire         ramp_dn   = (mode_i == `RAMP_MODE_DOWN);
	wire         want_on   = run_i & ~sleep_i;
	wire [7:0]   pace_end  = (8'h01 << {speed_i, 1'b0}) - 8'h01;
	wire [DW-1:0] target   = want_on ? HALF : ZERO;
	wire [DW-1:0] duty     = (silence_i || level_q != HALF) ? level_q : audio_i;

	always @(posedge divided_clock_output_i or posedge reset_i) begin
		if (reset_i) begin
			level_q <= ZERO;
			pace_q  <= 8'h00;
			busy_q  <= 1'b0;
			done_o  <= 1'b0;
			pwm_o   <= 1'b0;
		end else begin
			done_o <= 1'b0;
			pwm_o  <= run_i && (duty > phase_i);
			if (!run_i) begin
				level_q <= ZERO;
				busy_q  <= 1'b0;
				// Drop any part-counted step so the next ramp starts on time
				pace_q  <= 8'h00;
			end else if (level_q != target) begin
				if ((want_on && ramp_up) || (!want_on && ramp_dn && busy_q)) begin
					busy_q <= 1'b1;
					pace_q <= pace_q + 8'h01;
					if (pace_q >= pace_end) begin
						pace_q  <= 8'h00;
						level_q <= want_on ? level_q + {{(DW-1){1'b0}}, 1'b1}
							: level_q - {{(DW-1){1'b0}}, 1'b1};
					end
				end else if (!want_on && ramp_dn && !busy_q && level_q == HALF) begin
					busy_q <= 1'b1;
				end else begin
					level_q <= target;
					busy_q  <= 1'b0;
				end
			end else begin
				if (busy_q)
					done_o <= 1'b1;
				busy_q <= 1'b0;
				pace_q <= 8'h00;
			end
		end
	end
endmodule

// ===== hdl/amp_power_sequencer.v
// Power sequencer top: register file, wake control, clock divider, lock, channels
`timescale 1ns/1ps
`include "amp_seq_defines.vh"
module amp_power_sequencer #(
	parameter NCH = 6,
	parameter DW  = 8
) (
	input  wire            divided_clock_output_i,
	input  wire            reset_i,
	input  wire            crystal_input_i,
	input  wire            mute_pin_i,
	input  wire            audio_clocks_running_i,
	input  wire            wr_en_i,
	input  wire            rd_en_i,
	input  wire [7:0]      addr_i,
	input  wire [7:0]      wdata_i,
	input  wire [NCH*DW-1:0] audio_i,
	input  wire [23:0]     decimator_result_i,
	output reg  [7:0]      rdata_o,
	output wire [NCH-1:0]  pulse_width_output_pins_o,
	output wire            divided_clock_output_o,
	output wire            low_power_o,
	output wire            feedback_clear_o,
	output wire            feedback_run_o,
	output wire [23:0]     feedback_coef_o,
	output reg             irq_o
);
	// ===========================================================
	// Registers
	reg [7:0] power_ctrl_q;
	reg [7:0] chan_sleep_q;
	reg [7:0] ramp_cfg_q;
	reg [7:0] silence_q;
	reg [7:0] irq_cfg_q;
	reg [7:0] coef_hi_q;
	reg [7:0] coef_mid_q;
	reg [7:0] coef_lo_q;
	reg [7:0] fb_ctrl_q;
	reg       locked_q;
	reg       lock_evt_q;
	reg       ramp_evt_q;
	wire [NCH-1:0] chan_done;
	wire      status_rd = rd_en_i && (addr_i == `ADDR_STATUS);

	always @(posedge divided_clock_output_i or posedge reset_i) begin
		if (reset_i) begin
			power_ctrl_q <= `RST_POWER_CTRL;
			chan_sleep_q <= `RST_CHAN_SLEEP;
			ramp_cfg_q   <= `RST_RAMP_CFG;
			silence_q    <= `RST_CHAN_SILENCE;
			irq_cfg_q    <= `RST_IRQ_CFG;
			coef_hi_q    <= `RST_FB_COEF;
			coef_mid_q   <= `RST_FB_COEF;
			coef_lo_q    <= `RST_FB_COEF;
			fb_ctrl_q    <= `RST_FB_CTRL;
		end else if (wr_en_i) begin
			case (addr_i)
				`ADDR_POWER_CTRL:   power_ctrl_q <= wdata_i;
				`ADDR_CHAN_SLEEP:   chan_sleep_q <= wdata_i;
				`ADDR_RAMP_CFG:     ramp_cfg_q   <= wdata_i;
				`ADDR_CHAN_SILENCE: silence_q    <= wdata_i;
				`ADDR_IRQ_CFG:      irq_cfg_q    <= wdata_i;
				`ADDR_FB_COEF_HI:   coef_hi_q    <= wdata_i;
				`ADDR_FB_COEF_MID:  coef_mid_q   <= wdata_i;
				`ADDR_FB_COEF_LO:   coef_lo_q    <= wdata_i;
				`ADDR_FB_CTRL:      fb_ctrl_q    <= wdata_i;
				default: ;
			endcase
		end
	end

	always @(posedge divided_clock_output_i or posedge reset_i) begin
		if (reset_i)
			rdata_o <= 8'h00;
		else if (rd_en_i) begin
			case (addr_i)
				`ADDR_POWER_CTRL:   rdata_o <= power_ctrl_q;
				`ADDR_CHAN_SLEEP:   rdata_o <= chan_sleep_q;
				`ADDR_RAMP_CFG:     rdata_o <= ramp_cfg_q;
				`ADDR_CHAN_SILENCE: rdata_o <= silence_q;
				`ADDR_IRQ_CFG:      rdata_o <= irq_cfg_q;
				`ADDR_FB_COEF_HI:   rdata_o <= coef_hi_q;
				`ADDR_FB_COEF_MID:  rdata_o <= coef_mid_q;
				`ADDR_FB_COEF_LO:   rdata_o <= coef_lo_q;
				`ADDR_FB_CTRL:      rdata_o <= fb_ctrl_q;
				`ADDR_STATUS:       rdata_o <= {4'h0, ramp_evt_q, lock_evt_q, locked_q, low_power_o};
				`ADDR_DEC_HI:       rdata_o <= decimator_result_i[23:16];
				`ADDR_DEC_MID:      rdata_o <= decimator_result_i[15:8];
				`ADDR_DEC_LO:       rdata_o <= decimator_result_i[7:0];
				default:            rdata_o <= 8'h00;
			endcase
		end
	end

	assign low_power_o      = power_ctrl_q[`POWER_SLEEP_BIT];
	assign feedback_clear_o = fb_ctrl_q[`FB_CLEAR_BIT];
	assign feedback_run_o   = fb_ctrl_q[`FB_RUN_BIT];
	assign feedback_coef_o  = {coef_hi_q, coef_mid_q, coef_lo_q};

	// ===========================================================
	// Divided clock, divider chosen by mute pin caught at release
	reg       rel_seen_q;
	reg       div2_q;
	reg       half_q;
	reg       xtal_q;
	always @(posedge divided_clock_output_i or posedge reset_i) begin
		if (reset_i) begin
			rel_seen_q <= 1'b0;
			div2_q     <= 1'b0;
			half_q     <= 1'b0;
			xtal_q     <= 1'b0;
		end else begin
			rel_seen_q <= 1'b1;
			xtal_q     <= crystal_input_i;
			if (!rel_seen_q)
				div2_q <= mute_pin_i;
			if (crystal_input_i && !xtal_q)
				half_q <= ~half_q;
		end
	end
	// Crystal taken as a level; halving toggles once per sampled rising edge,
	// so the crystal must stay below half the system clock
	assign divided_clock_output_o = div2_q ? half_q : crystal_input_i;

	// ===========================================================
	// Rate converter lock
	localparam [31:0] LOCK_LAST = `LOCK_CYCLES - 1;
	reg [15:0] lock_cnt_q;
	wire       lock_hit = ({16'h0000, lock_cnt_q} == LOCK_LAST);
	always @(posedge divided_clock_output_i or posedge reset_i) begin
		if (reset_i) begin
			lock_cnt_q <= 16'h0000;
			locked_q   <= 1'b0;
		end else if (low_power_o || !audio_clocks_running_i) begin
			lock_cnt_q <= 16'h0000;
			locked_q   <= 1'b0;
		end else if (!locked_q) begin
			lock_cnt_q <= lock_cnt_q + 16'h0001;
			if (lock_hit)
				locked_q <= 1'b1;
		end
	end

	// ===========================================================
	// Events, cleared by status read; a new event wins over the clear
	wire lock_rise = !locked_q && !low_power_o && audio_clocks_running_i
		&& lock_hit;
	always @(posedge divided_clock_output_i or posedge reset_i) begin
		if (reset_i) begin
			lock_evt_q <= 1'b0;
			ramp_evt_q <= 1'b0;
			irq_o      <= 1'b0;
		end else begin
			lock_evt_q <= lock_rise | (lock_evt_q & ~status_rd);
			ramp_evt_q <= (|chan_done) | (ramp_evt_q & ~status_rd);
			irq_o <= (lock_evt_q & irq_cfg_q[`IRQ_LOCK_BIT])
				| (ramp_evt_q & irq_cfg_q[`IRQ_RAMP_BIT]);
		end
	end

	// ===========================================================
	// Channels
	reg [DW-1:0] phase_q;
	always @(posedge divided_clock_output_i or posedge reset_i) begin
		if (reset_i)
			phase_q <= {DW{1'b0}};
		else
			phase_q <= phase_q + {{(DW-1){1'b0}}, 1'b1};
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : ch
			chan_ramp #(.DW(DW)) u_chan (
				.divided_clock_output_i (divided_clock_output_i),
				.reset_i   (reset_i),
				.run_i     (~low_power_o),
				.sleep_i   (chan_sleep_q[g]),
				.silence_i (silence_q[g]),
				.mode_i    (ramp_cfg_q[`RAMP_MODE_LSB+1:`RAMP_MODE_LSB]),
				.speed_i   (ramp_cfg_q[`RAMP_SPD_LSB+1:`RAMP_SPD_LSB]),
				.audio_i   (audio_i[g*DW +: DW]),
				.phase_i   (phase_q),
				.pwm_o     (pulse_width_output_pins_o[g]),
				.done_o    (chan_done[g])
			);
		end
	endgenerate
endmodule

// ===== tb/amp_power_sequencer_monitor.sv
// Port checker of the power sequencer
`timescale 1ns/1ps
module amp_seq_monitor #(parameter NCH = 6) (
	input logic           divided_clock_output_i,
	input logic           reset_i,
	input logic           crystal_input_i,
	input logic           mute_pin_i,
	input logic           audio_clocks_running_i,
	input logic           wr_en_i,
	input logic           rd_en_i,
	input logic [7:0]     addr_i,
	input logic [7:0]     wdata_i,
	input logic [7:0]     rdata_o,
	input logic [NCH-1:0] pulse_width_output_pins_o,
	input logic           divided_clock_output_o,
	input logic           low_power_o,
	input logic           irq_o
);
	default clocking @(posedge divided_clock_output_i); endclocking
	default disable iff (reset_i);
	logic       rel_q, m_q, fresh_q;
	logic [1:0] irq_q;
	logic [7:0] run_q;
	always_ff @(posedge divided_clock_output_i or posedge reset_i) begin
		if (reset_i) begin
			rel_q <= 1'h1;
			m_q <= 1'h0;
			fresh_q <= 1'h1;
			irq_q <= 2'h0;
			run_q <= 8'h00;
		end else begin
			rel_q <= 1'h0;
			if (rel_q)
				m_q <= mute_pin_i;
			if (wr_en_i && addr_i == 8'h03 && wdata_i != 8'hff)
				fresh_q <= 1'h0;
			if (wr_en_i && addr_i == 8'h2a)
				irq_q <= wdata_i[1:0];
			// Saturate so a long run never wraps under the lock count
			if (!audio_clocks_running_i)
				run_q <= 8'h00;
			else if (!low_power_o && run_q != 8'hff)
				run_q <= run_q + 8'h01;
		end
	end
	// ==========================================
	// Properties
	sequence s_pwr_wr;
		wr_en_i && addr_i == 8'h02;
	endsequence
	property p_rst; $fell(reset_i) |-> low_power_o && pulse_width_output_pins_o == 0; endproperty
	property p_wake; s_pwr_wr |=> low_power_o == $past(wdata_i[0]); endproperty
	property p_unmap; rd_en_i && addr_i == 8'h7f |=> rdata_o == 8'h00; endproperty
	property p_hold; !rd_en_i |=> $stable(rdata_o); endproperty
	property p_clamp; fresh_q |-> pulse_width_output_pins_o == 0; endproperty
	property p_mask; irq_q == 2'h0 && $past(irq_q) == 2'h0 |-> !irq_o; endproperty
	property p_lock; $rose(irq_o) && irq_q == 2'h1 |-> run_q >= 8'h63; endproperty
	property p_div; !rel_q && !m_q |-> divided_clock_output_o == crystal_input_i; endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	a_wake: assert property (p_wake) else $error("sleep bit wrong");
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	a_hold: assert property (p_hold) else $error("read data moved");
	a_clamp: assert property (p_clamp) else $error("output not grounded");
	a_mask: assert property (p_mask) else $error("masked irq");
	a_lock: assert property (p_lock) else $error("early lock");
	a_div: assert property (p_div) else $error("clock not passed");
endmodule
bind amp_power_sequencer amp_seq_monitor #(.NCH(NCH)) chk (.*);

// ===== tb/host_stage_model.sv
// Far side: crystal, audio port clocks and decimator
`timescale 1ns/1ps
module host_stage_model (
	input  logic        divided_clock_output_i,
	input  logic        start_i,
	output logic        crystal_o = 1'h0,
	output logic        running_o = 1'h0,
	output logic [23:0] decimator_o = 24'h5a3c96
);
	logic [1:0] ph_q = 2'h0;
	always @(posedge divided_clock_output_i) begin
		ph_q <= ph_q + 2'h1;
		crystal_o <= ph_q[1];
		running_o <= start_i;
		// Churns every cycle so a stale sample never looks fresh
		decimator_o <= {decimator_o[22:0], ~decimator_o[23]};
	end
endmodule

// ===== tb/amp_power_sequencer_bench.sv
// Self-checking bench of the power sequencer
`timescale 1ns/1ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
	$display("ERROR %s exp %0h got %0h", n, e, a); end end
module amp_power_sequencer_bench;
	logic divided_clock_output_i = 0, reset_i = 1, mute_pin_i = 0, wr_en_i = 0, rd_en_i = 0, go = 0;
	logic [7:0] addr_i = 0, wdata_i = 0, rdata_o, d;
	logic [47:0] audio_i = 0;
	logic [23:0] dec, coef, e;
	logic [5:0] pins;
	logic xtal, run, divo, lowp, fclr, frun, irq_o;
	logic [31:0] seed = 32'he28a90c4, v;
	logic [7:0] ra[10] = '{8'h02, 8'h03, 8'h05, 8'h13, 8'h2a, 8'h35, 8'h36, 8'h37, 8'h38, 8'h7f};
	logic [7:0] rv[10] = '{8'h81, 8'hff, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	int err_count = 0, samples_checked = 0, c, k;
	always #5 divided_clock_output_i = ~divided_clock_output_i;
	host_stage_model far (.divided_clock_output_i(divided_clock_output_i), .start_i(go), .crystal_o(xtal),
		.running_o(run), .decimator_o(dec));
	amp_power_sequencer dut (.divided_clock_output_i(divided_clock_output_i), .reset_i(reset_i), .crystal_input_i(xtal),
		.mute_pin_i(mute_pin_i), .audio_clocks_running_i(run), .wr_en_i(wr_en_i),
		.rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .audio_i(audio_i),
		.decimator_result_i(dec), .rdata_o(rdata_o), .pulse_width_output_pins_o(pins),
		.divided_clock_output_o(divo), .low_power_o(lowp), .feedback_clear_o(fclr),
		.feedback_run_o(frun), .feedback_coef_o(coef), .irq_o(irq_o));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int ramp_len(input int s);
		return 128 << (2 * s);
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge divided_clock_output_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, x);
		@(posedge divided_clock_output_i);
		wr_en_i <= 1;
		addr_i <= a;
		wdata_i <= x;
		tick(1);
		wr_en_i <= 0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] x);
		@(posedge divided_clock_output_i);
		rd_en_i <= 1;
		addr_i <= a;
		tick(1);
		rd_en_i <= 0;
		x = rdata_o;
	endtask
	// Counts rising edges of the divided clock, or high cycles of one channel
	task automatic cnt(input int ch, len, output int n);
		logic p;
		n = 0;
		p = divo;
		repeat (len) begin
			tick(1);
			n += (ch > 5) ? int'(divo && !p) : int'(pins[ch]);
			p = divo;
		end
	endtask
	task automatic wirq(output int n);
		n = 0;
		while (irq_o !== 1'h1) begin
			tick(1);
			n++;
			if (n > 2000) begin
				err_count++;
				tally_and_finish();
			end
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		tick(20);
		reset_i <= 0;
		for (k = 0; k < 10; k++) begin
			rd(ra[k], d);
			`CHK("reg default", rv[k], d)
		end
		cnt(6, 40, c);
		`CHK("div edges", 10, c)
		$display("defaults done");
		// ==========================================
		// Host wake, lock and soft ramps
		wr(8'h13, 8'h3f);
		wr(8'h05, 8'h19);
		// minimum pulse field sits outside this block; nothing to program
		wr(8'h2a, 8'h01);
		wr(8'h02, 8'h00);
		`CHK("sleep", 1'h0, lowp)
		go <= 1;
		wirq(c);
		`CHK("lock time", 1'h1, c >= 100 && c <= 110)
		rd(8'h39, d);
		`CHK("status lock", 8'h06, d)
		wr(8'h2a, 8'h02);
		wr(8'h03, 8'hfe);
		wirq(c);
		`CHK("ramp up", 1'h1, c >= ramp_len(1) - 2 && c <= ramp_len(1) + 8)
		`CHK("others", 5'h00, pins[5:1])
		cnt(0, 256, c);
		`CHK("mute duty", 1'h1, c >= 126 && c <= 130)
		wr(8'h05, 8'h08);
		rd(8'h39, d);
		`CHK("status ramp", 8'h0a, d)
		wr(8'h03, 8'hff);
		wirq(c);
		`CHK("ramp down", 1'h1, c >= ramp_len(0) - 2 && c <= ramp_len(0) + 8)
		rd(8'h39, d);
		`CHK("status down", 8'h0a, d)
		rd(8'h39, d);
		`CHK("status cleared", 8'h02, d)
		cnt(0, 256, c);
		`CHK("grounded", 0, c)
		$display("ramps done");
		wr(8'h05, 8'h00);
		wr(8'h13, 8'h00);
		v = xs();
		audio_i <= {6{v[7:0] | 8'h20}};
		wr(8'h03, 8'hfd);
		cnt(1, 256, c);
		`CHK("direct duty", 1'h1, c >= (v[7:0] | 8'h20) - 2 && c <= (v[7:0] | 8'h20) + 2)
		wr(8'h03, 8'hff);
		tick(2);
		cnt(1, 256, c);
		`CHK("direct off", 0, c)
		wr(8'h35, 8'h22);
		wr(8'h36, 8'h00);
		wr(8'h37, 8'h00);
		`CHK("coef", 24'h220000, coef)
		wr(8'h38, 8'h03);
		`CHK("fb run", 2'h3, {frun, fclr})
		wr(8'h38, 8'h01);
		`CHK("fb run low", 2'h1, {frun, fclr})
		for (k = 0; k < 3; k++) begin
			rd(8'h3a + k, d);
			// Model shifts every edge; undo one step to get the sampled word
			e = {~dec[0], dec[23:1]};
			`CHK("decimator", e[23 - 8 * k -: 8], d)
		end
		for (k = 0; k < 6; k++) begin
			v = xs();
			wr(8'h35 + k % 3, v[7:0]);
			rd(8'h35 + k % 3, d);
			`CHK("coef rw", v[7:0], d)
		end
		wr(8'h02, 8'h01);
		`CHK("sleep again", 1'h1, lowp)
		$display("direct and feedback done");
		reset_i <= 1;
		mute_pin_i <= 1;
		tick(20);
		`CHK("held pins", 6'h00, pins)
		reset_i <= 0;
		tick(2);
		cnt(6, 40, c);
		`CHK("div half", 5, c)
		`CHK("low power", 1'h1, lowp)
		$display("second reset done");
		tally_and_finish();
	end
endmodule
